// file: core/smd_alu.sv
// Arithmetic unit: timed multiply and divide, and an immediate round, on the double-length accumulator.
`default_nettype none
`include "smd_defs.svh"
module smd_alu (
	input wire logic clock,
	input wire logic nrst,
	smd_alu_if.alu io
);
	logic [`SMD_CNT_W-1:0] cnt, next_cnt;
	logic [31:0] acc, next_acc;
	logic [31:0] pend, next_pend;

	function automatic logic [31:0] mul_res(input logic [15:0] x, input logic [15:0] y,
		input logic neg, input logic frac, input logic [31:0] add);
		logic signed [31:0] p;
		p = $signed(x) * $signed(y);
		if (frac)
			p = p <<< 1;
		mul_res = (neg ? 32'(-p) : 32'(p)) + add;
	endfunction

	function automatic logic [31:0] div_res(input logic [31:0] dd, input logic [15:0] x,
		input logic frac, input logic [31:0] keep);
		logic signed [32:0] num, den, q, r;
		num = {dd[31], dd};
		den = {{17{x[15]}}, x};
		if (frac)
			den = den <<< 1;
		if (x == `SMD_HALF_ZERO) begin
			div_res = keep;
		end else begin
			q = num / den;
			r = num % den;
			// Remainder keeps the dividend's sign, as signed % does.
			div_res = {q[15:0], r[15:0]};
		end
	endfunction

	// The result is formed at start and released after the fixed run time; the
	// operands are therefore captured at once, which frees the first rank for reloads.
	always_comb begin
		next_cnt = cnt;
		next_acc = acc;
		next_pend = pend;
		if (io.start && cnt == `SMD_CNT_ZERO) begin
			case (io.kind)
				smd_pkg::kind_mul: begin
					next_pend = mul_res(io.x, io.y, io.neg, io.frac, io.addend);
					next_cnt = `SMD_MUL_CYCLES;
				end
				smd_pkg::kind_div: begin
					next_pend = div_res(io.dividend, io.x, io.frac, acc);
					// Fractional division runs one period shorter.
					next_cnt = `SMD_DIV_CYCLES - {4'h0, io.frac};
				end
				default: next_acc = (acc + `SMD_ROUND_ADD) & `SMD_HIGH_MASK;
			endcase
		end else if (cnt != `SMD_CNT_ZERO) begin
			next_cnt = cnt - `SMD_CNT_LAST;
			if (cnt == `SMD_CNT_LAST)
				next_acc = pend;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			cnt <= `SMD_CNT_ZERO;
			acc <= `SMD_ACC_ZERO;
			pend <= `SMD_ACC_ZERO;
		end else begin
			cnt <= next_cnt;
			acc <= next_acc;
			pend <= next_pend;
		end
	end

	assign io.acc = acc;
	assign io.busy = cnt != `SMD_CNT_ZERO;
	assign io.done = cnt == `SMD_CNT_LAST;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	a_mul_time: assert property (io.start && !io.busy && io.kind == smd_pkg::kind_mul
		|-> !io.done [*8] ##1 io.done)
		else $error("multiply did not finish in eight periods");
	a_div_time: assert property (io.start && !io.busy && io.kind == smd_pkg::kind_div && !io.frac
		|-> ##20 io.done)
		else $error("integer divide did not finish in twenty periods");
	a_acc_update: assert property (io.done |=> io.acc == $past(pend))
		else $error("accumulator not updated at completion");
endmodule
`default_nettype wire

// file: core/smd_alu_if.sv
// Link between the sequencer and its arithmetic unit.
`default_nettype none
interface smd_alu_if;
	logic start;
	smd_pkg::smd_kind_t kind;
	logic neg;
	logic frac;
	logic [15:0] x;
	logic [15:0] y;
	logic [31:0] addend;
	logic [31:0] dividend;
	logic [31:0] acc;
	logic busy;
	logic done;
	modport seq (output start, kind, neg, frac, x, y, addend, dividend, input acc, busy, done);
	modport alu (input start, kind, neg, frac, x, y, addend, dividend, output acc, busy, done);
endinterface
`default_nettype wire

// file: core/smd_defs.svh
// Constants for the sequential multiplier/divider sequencer.
`ifndef SMD_DEFS_SVH
`define SMD_DEFS_SVH
`define SMD_DATA_W 16
`define SMD_ACC_W 32
`define SMD_ACC_ZERO 32'h00000000
`define SMD_CODE_MUL_MAX 3'h3
`define SMD_CODE_DIV_DBL 3'h4
`define SMD_CODE_FRAC 3'h5
`define SMD_CODE_INT 3'h6
`define SMD_CODE_READ 3'h7
`define SMD_LOADS_NONE 2'h0
`define SMD_LOADS_X 2'h1
`define SMD_LOADS_XZ 2'h2
`define SMD_LOADS_XZW 2'h3
`define SMD_CNT_W 5
`define SMD_MUL_CYCLES 5'h08
`define SMD_DIV_CYCLES 5'h14
`define SMD_CNT_ZERO 5'h00
`define SMD_CNT_LAST 5'h01
`define SMD_HALF_ZERO 16'h0000
`define SMD_ROUND_ADD 32'h00008000
`define SMD_HIGH_MASK 32'hffff0000
`endif

// file: core/smd_pkg.sv
// Types and helpers shared by the multiplier/divider sequencer modules.
`default_nettype none
package smd_pkg;
	typedef enum logic [1:0] {kind_mul, kind_div, kind_round} smd_kind_t;
	typedef enum logic [3:0] {
		st_idle, st_load, st_run, st_done_mul, st_done_div, st_read_hi, st_read_lo
	} smd_state_t;
	function automatic logic [31:0] smd_sext(input logic [15:0] v);
		smd_sext = {{16{v[15]}}, v};
	endfunction
endpackage
`default_nettype wire

// file: core/smd_seq.sv
// Sequencer of a 16-bit bus-oriented sequential multiplier/divider.
`default_nettype none
`include "smd_defs.svh"
// Behaviour
// - Action and next state each period follow from present state and current code.
// - After a read or round the sequencer returns to idle and starts afresh.
// - Chained operations skip idle and continue from the multiply or divide end state.
// - The multiplicand is two-rank so a new one may load while an operation runs.
// - Without a fresh multiplicand the previously held one is reused.
// - Each arithmetic operation has its own code sequence and duration and may chain.
// - A round or read is accepted at the end of any arithmetic operation.
// - After the multiplicand a code 6 loads the high addend half used by codes 0 and 1.
// - A second code 6 loads the low half, giving a double or sign-extended addend.
// - Code 5 on the first load selects fractions, code 6 selects integers.
// - While activation is high the device ignores codes and floats the bus; a running operation still counts on to its end state.
// - Code 7 with activation low drives the high half, then the low half next period.
// - A read code during loading aborts the load and returns to idle, except after a lone fraction multiplicand, where it rounds and reads.
module smd_seq (
	input wire logic clock,
	input wire logic nrst,
	input wire logic op_code_bit2,
	input wire logic op_code_bit1,
	input wire logic op_code_bit0,
	input wire logic go_n,
	input wire logic [`SMD_DATA_W-1:0] bus_in,
	output logic [`SMD_DATA_W-1:0] bus_out,
	output logic bus_oe
);
	smd_alu_if alu_link ();

	smd_alu u_alu (
		.clock(clock),
		.nrst(nrst),
		.io(alu_link.alu)
	);

	smd_pkg::smd_state_t st, next_st;
	logic [1:0] loads, next_loads;
	logic [15:0] held_multiplicand, next_held;
	logic [15:0] z_in, next_z;
	logic [15:0] w_in, next_w;
	logic frac, next_frac;
	logic div_op, next_div;
	logic start;
	smd_pkg::smd_kind_t kind;
	logic [2:0] code;
	logic [31:0] acc;
	logic armed;

	assign code = {op_code_bit2, op_code_bit1, op_code_bit0};
	assign acc = alu_link.acc;
	assign armed = st == smd_pkg::st_idle || st == smd_pkg::st_load
		|| st == smd_pkg::st_done_mul || st == smd_pkg::st_done_div;

	// Addend picked by how many operands were loaded and whether the code accumulates.
	function automatic logic [31:0] mul_addend(input logic [1:0] n, input logic acc_sel,
		input logic [31:0] k, input logic [15:0] z, input logic [15:0] w);
		case (n)
			`SMD_LOADS_XZ: mul_addend = acc_sel ? smd_pkg::smd_sext(k[31:16])
				: {z, `SMD_HALF_ZERO};
			`SMD_LOADS_XZW: mul_addend = acc_sel ? smd_pkg::smd_sext(w) : {z, w};
			default: mul_addend = acc_sel ? k : `SMD_ACC_ZERO;
		endcase
	endfunction

	function automatic logic [31:0] div_dividend(input logic [1:0] n, input logic single,
		input logic [31:0] k, input logic [15:0] z, input logic [15:0] w,
		input logic [15:0] b);
		case (n)
			`SMD_LOADS_X: div_dividend = single ? smd_pkg::smd_sext(k[31:16])
				: smd_pkg::smd_sext(k[15:0]);
			`SMD_LOADS_XZ: div_dividend = single ? smd_pkg::smd_sext(z) : {z, b};
			`SMD_LOADS_XZW: div_dividend = smd_pkg::smd_sext(w);
			default: div_dividend = k;
		endcase
	endfunction

	assign alu_link.start = start;
	assign alu_link.kind = kind;
	assign alu_link.neg = code[0];
	assign alu_link.frac = frac;
	// The unit captures this first rank at start, forming the second rank.
	assign alu_link.x = held_multiplicand;
	assign alu_link.y = bus_in;
	assign alu_link.addend = mul_addend(loads, code[1], acc, z_in, w_in);
	assign alu_link.dividend = div_dividend(loads, code == `SMD_CODE_FRAC, acc, z_in, w_in,
		bus_in);

	always_comb begin
		next_st = st;
		next_loads = loads;
		next_held = held_multiplicand;
		next_z = z_in;
		next_w = w_in;
		next_frac = frac;
		next_div = div_op;
		start = 1'b0;
		kind = smd_pkg::kind_mul;
		case (st)
			smd_pkg::st_run: begin
				// Loading while processing saves a period in chained work.
				if (!go_n && (code == `SMD_CODE_FRAC || code == `SMD_CODE_INT)) begin
					next_held = bus_in;
					next_loads = `SMD_LOADS_X;
					next_frac = code == `SMD_CODE_FRAC;
				end
				if (alu_link.done)
					next_st = div_op ? smd_pkg::st_done_div : smd_pkg::st_done_mul;
			end
			smd_pkg::st_idle, smd_pkg::st_load, smd_pkg::st_done_mul,
			smd_pkg::st_done_div: begin
				if (!go_n) begin
					if (code <= `SMD_CODE_MUL_MAX) begin
						start = 1'b1;
						next_st = smd_pkg::st_run;
						next_loads = `SMD_LOADS_NONE;
						next_div = 1'b0;
					end else if (code == `SMD_CODE_DIV_DBL
						|| (code == `SMD_CODE_FRAC && loads != `SMD_LOADS_NONE)) begin
						start = 1'b1;
						kind = smd_pkg::kind_div;
						next_st = smd_pkg::st_run;
						next_loads = `SMD_LOADS_NONE;
						next_div = 1'b1;
					end else if (code == `SMD_CODE_READ) begin
						next_loads = `SMD_LOADS_NONE;
						if (loads == `SMD_LOADS_NONE) begin
							next_st = smd_pkg::st_read_hi;
						end else if (loads == `SMD_LOADS_X && frac) begin
							start = 1'b1;
							kind = smd_pkg::kind_round;
							next_st = smd_pkg::st_read_hi;
						end else begin
							next_st = smd_pkg::st_idle;
						end
					end else if (loads == `SMD_LOADS_NONE) begin
						next_held = bus_in;
						next_frac = code == `SMD_CODE_FRAC;
						next_loads = `SMD_LOADS_X;
						next_st = smd_pkg::st_load;
					end else if (loads == `SMD_LOADS_X) begin
						next_z = bus_in;
						next_w = `SMD_HALF_ZERO;
						next_loads = `SMD_LOADS_XZ;
						next_st = smd_pkg::st_load;
					end else if (loads == `SMD_LOADS_XZ) begin
						next_w = bus_in;
						next_loads = `SMD_LOADS_XZW;
						next_st = smd_pkg::st_load;
					end else begin
						// A fourth load is incomplete; it is dropped back to idle.
						next_loads = `SMD_LOADS_NONE;
						next_st = smd_pkg::st_idle;
					end
				end
			end
			smd_pkg::st_read_hi: begin
				if (!go_n)
					next_st = code == `SMD_CODE_READ ? smd_pkg::st_read_lo
						: smd_pkg::st_idle;
			end
			smd_pkg::st_read_lo: begin
				if (!go_n)
					next_st = code == `SMD_CODE_READ ? smd_pkg::st_read_hi
						: smd_pkg::st_idle;
			end
			default: next_st = smd_pkg::st_idle;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			st <= smd_pkg::st_idle;
			loads <= `SMD_LOADS_NONE;
			held_multiplicand <= `SMD_HALF_ZERO;
			z_in <= `SMD_HALF_ZERO;
			w_in <= `SMD_HALF_ZERO;
			frac <= 1'b0;
			div_op <= 1'b0;
		end else begin
			st <= next_st;
			loads <= next_loads;
			held_multiplicand <= next_held;
			z_in <= next_z;
			w_in <= next_w;
			frac <= next_frac;
			div_op <= next_div;
		end
	end

	// Bus data is a select between accumulator flip-flops; no extra stage is added.
	assign bus_oe = !go_n && (st == smd_pkg::st_read_hi || st == smd_pkg::st_read_lo);
	assign bus_out = st == smd_pkg::st_read_lo ? acc[15:0] : acc[31:16];

	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	a_float_idle: assert property (go_n |-> !bus_oe)
		else $error("bus driven while activation high");
	a_hold_on_go: assert property (go_n && st != smd_pkg::st_run
		|=> st == $past(st) && !alu_link.busy || $past(alu_link.busy))
		else $error("state moved while activation high");
	a_read_low: assert property (st == smd_pkg::st_read_hi && !go_n && code == `SMD_CODE_READ
		|=> st == smd_pkg::st_read_lo && bus_out == acc[15:0])
		else $error("low half not read after high half");
	a_read_end: assert property (st == smd_pkg::st_read_lo && !go_n && code != `SMD_CODE_READ
		|=> st == smd_pkg::st_idle)
		else $error("read did not return to idle");
	a_load_abort: assert property (st == smd_pkg::st_load && !go_n && code == `SMD_CODE_READ
		&& !(loads == `SMD_LOADS_X && frac) |=> st == smd_pkg::st_idle
		&& loads == `SMD_LOADS_NONE)
		else $error("read during load did not abort");
	a_mul_chain: assert property (armed && !go_n && code <= `SMD_CODE_MUL_MAX
		|=> st == smd_pkg::st_run [*8] ##1 st == smd_pkg::st_done_mul)
		else $error("multiply did not end in its chain state");
	a_x_rank: assert property (st == smd_pkg::st_run && !go_n && code == `SMD_CODE_INT
		|=> held_multiplicand == $past(bus_in) && st != smd_pkg::st_idle)
		else $error("multiplicand not loaded during run");
	a_x_reuse: assert property (st == smd_pkg::st_idle && !go_n && code <= `SMD_CODE_MUL_MAX
		|=> $stable(held_multiplicand))
		else $error("held multiplicand lost on plain multiply");

	c_chain_mul: cover property (st == smd_pkg::st_done_mul && !go_n && code == 3'h2);
	c_read_pair: cover property (st == smd_pkg::st_read_hi ##1 st == smd_pkg::st_read_lo);
	c_div_done: cover property (st == smd_pkg::st_done_div);
	c_round: cover property (start && kind == smd_pkg::kind_round);
endmodule
`default_nettype wire

// file: verification/smd_bus_model.sv
// Shared data bus model: resolves host and device drive and moves when nobody drives it.
`default_nettype none
module smd_bus_model (
	input wire logic clock,
	input wire logic host_oe,
	input wire logic [15:0] host_data,
	input wire logic bus_oe,
	input wire logic [15:0] bus_out,
	output logic [15:0] bus_wire
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] last = 16'h0000;
	// The bus has no pull, so a released bus shows the inverse of its last level.
	assign bus_wire = bus_oe ? bus_out : (host_oe ? host_data : ~last);
	always @(posedge clock) begin
		last <= bus_wire;
	end
endmodule
`default_nettype wire

// file: verification/smd_seq_tb.sv
// Self-checking bench for the multiplier/divider sequencer.
`default_nettype none
module smd_seq_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		int nl;
		logic [2:0] fmt;
		logic [2:0] code;
		logic [15:0] x, z, w, y;
		logic [31:0] e;
	} smd_row_t;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic go_n = 1'b1;
	logic [2:0] code = 3'h0;
	logic host_oe = 1'b0;
	logic [15:0] host_data = 16'h0000;
	wire logic [15:0] bus_wire;
	wire logic [15:0] bus_out;
	wire logic bus_oe;
	int mismatches = 0;
	int num_checks = 0;
	int cycles = 0;
	// Load count, format code, operation code, operands and the expected accumulator.
	smd_row_t rows [10] = '{
		'{1, 3'h6, 3'h0, 16'h0003, 16'h0000, 16'h0000, 16'hfffb, 32'hfffffff1},
		'{0, 3'h6, 3'h1, 16'h0000, 16'h0000, 16'h0000, 16'h0007, 32'hffffffeb},
		'{0, 3'h6, 3'h2, 16'h0000, 16'h0000, 16'h0000, 16'h0002, 32'hfffffff1},
		'{0, 3'h6, 3'h3, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 32'hffffffee},
		'{1, 3'h5, 3'h0, 16'h4000, 16'h0000, 16'h0000, 16'h4000, 32'h20000000},
		'{2, 3'h6, 3'h0, 16'h0002, 16'h0001, 16'h0000, 16'h0003, 32'h00010006},
		'{2, 3'h6, 3'h1, 16'h0002, 16'hffff, 16'h0000, 16'h0003, 32'hfffefffa},
		'{2, 3'h6, 3'h2, 16'h0002, 16'h0005, 16'h0000, 16'h0003, 32'h00000004},
		'{3, 3'h6, 3'h0, 16'h0002, 16'h0001, 16'h0005, 16'h0003, 32'h0001000b},
		'{3, 3'h6, 3'h3, 16'h0002, 16'h0001, 16'hfffe, 16'h0003, 32'hfffffff8}
	};
	smd_seq i_dut (
		.clock(clock),
		.nrst(nrst),
		.op_code_bit2(code[2]),
		.op_code_bit1(code[1]),
		.op_code_bit0(code[0]),
		.go_n(go_n),
		.bus_in(bus_wire),
		.bus_out(bus_out),
		.bus_oe(bus_oe)
	);
	smd_bus_model i_bus (
		.clock(clock),
		.host_oe(host_oe),
		.host_data(host_data),
		.bus_oe(bus_oe),
		.bus_out(bus_out),
		.bus_wire(bus_wire)
	);
	always #20 clock = ~clock;
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// A hung sequencer must not stall the run.
	always @(posedge clock) begin
		cycles++;
		if (cycles == 2000) begin
			mismatches++;
			results();
		end
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input logic g, input logic [2:0] c, input logic [15:0] d);
		@(posedge clock);
		go_n <= g;
		code <= c;
		host_data <= d;
		host_oe <= !g && c != 3'h7;
	endtask
	task automatic idle(input int n);
		repeat (n) cyc(1'b1, 3'h0, 16'h0000);
	endtask
	task automatic rd(input logic [31:0] e);
		cyc(1'b0, 3'h7, 16'h0000);
		cyc(1'b0, 3'h7, 16'h0000);
		#1;
		chk("bus_oe", 16'h0001, {15'h0000, bus_oe});
		chk("read high", e[31:16], bus_wire);
		cyc(1'b0, 3'h0, 16'h0000);
		#1;
		chk("read low", e[15:0], bus_out);
		idle(1);
	endtask
	task automatic mul(input smd_row_t r);
		if (r.nl > 0) cyc(1'b0, r.fmt, r.x);
		if (r.nl > 1) cyc(1'b0, 3'h6, r.z);
		if (r.nl > 2) cyc(1'b0, 3'h6, r.w);
		cyc(1'b0, r.code, r.y);
		idle(8);
	endtask
	initial begin
		repeat (6) @(posedge clock);
		nrst <= 1'b1;
		#1;
		chk("oe in reset", 16'h0000, {15'h0000, bus_oe});
		rd(32'h00000000);
		foreach (rows[i]) begin
			mul(rows[i]);
			rd(rows[i].e);
		end
		// Codes must be ignored and the bus left alone while the chip is inactive.
		repeat (3) cyc(1'b1, 3'h7, 16'h0000);
		#1;
		chk("oe inactive", 16'h0000, {15'h0000, bus_oe});
		cyc(1'b1, 3'h0, 16'h0005);
		idle(9);
		rd(32'hfffffff8);
		// A read in mid-load drops back to idle without starting anything.
		cyc(1'b0, 3'h6, 16'h0009);
		cyc(1'b0, 3'h7, 16'h0000);
		cyc(1'b0, 3'h7, 16'h0000);
		#1;
		chk("oe after abort", 16'h0000, {15'h0000, bus_oe});
		cyc(1'b0, 3'h0, 16'h0000);
		idle(1);
		rd(32'hfffffff8);
		// Preload a multiplicand during the run, then chain an accumulate from the end state.
		cyc(1'b0, 3'h6, 16'h0003);
		cyc(1'b0, 3'h0, 16'h0004);
		cyc(1'b0, 3'h6, 16'h000a);
		idle(7);
		cyc(1'b0, 3'h2, 16'h0005);
		idle(8);
		rd(32'h0000003e);
		// Double-length dividend from the high load and the bus: quotient high, remainder low.
		cyc(1'b0, 3'h6, 16'h0007);
		cyc(1'b0, 3'h6, 16'hffff);
		cyc(1'b0, 3'h4, 16'hffc2);
		idle(20);
		rd(32'hfff8fffa);
		// A fraction load followed straight by a read rounds the accumulator first.
		cyc(1'b0, 3'h5, 16'h0003);
		rd(32'hfff90000);
		results();
	end
endmodule
`default_nettype wire
